// ===== dv/ebm_fabric_model.sv
`timescale 1ns/1ps
// Fabric user logic: pulses a port clock around one request
module ebm_fabric_model
    import ebm_pkg::*;
(
    input wire logic clock,
    output logic wrClk,
    output logic wrClkEn,
    output logic wrEn,
    output logic [10:0] wrAddr,
    output logic [15:0] wrData,
    output logic [15:0] wrMask,
    output logic rdClk,
    output logic rdClkEn,
    output logic rdEn,
    output logic [10:0] rdAddr,
    input wire logic [15:0] rdData
);
    // Port clocks stand still low between requests
    initial begin
        {wrClk, wrClkEn, wrEn, wrAddr, wrData, wrMask} = '0;
        {rdClk, rdClkEn, rdEn, rdAddr} = '0;
    end
    // Both edges are given, so either polarity commits once
    task automatic wr(input logic [10:0] a, input logic [15:0] d,
            input logic [15:0] m, input logic we, input logic ce);
        @(posedge clock);
        wrClk <= 1'b1;
        wrEn <= we;
        wrClkEn <= ce;
        // One block only: a cascade would decode upper bits here
        wrAddr <= a;
        wrData <= d;
        wrMask <= m;
        repeat (3) @(posedge clock);
        wrClk <= 1'b0;
        repeat (3) @(posedge clock);
        // Released lines flip so stale values never look valid
        {wrEn, wrClkEn, wrAddr, wrData, wrMask} <= ~{we, ce, a, d, m};
    endtask
    task automatic rd(input logic [10:0] a, input logic re,
            input logic ce, output logic [15:0] q);
        @(posedge clock);
        rdClk <= 1'b1;
        rdEn <= re;
        rdClkEn <= ce;
        rdAddr <= a;
        repeat (3) @(posedge clock);
        rdClk <= 1'b0;
        repeat (4) @(posedge clock);
        q = rdData;
        {rdEn, rdClkEn, rdAddr} <= ~{re, ce, a};
    endtask
endmodule

// ===== dv/ebm_top_props.sv
`timescale 1ns/1ps
`include "ebm_defs.svh"
// Port-level checks on the APB answer and the read port
module ebm_top_props
    import ebm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rdClk,
    input wire logic rdClkEn,
    input wire logic rdEn,
    input wire logic [`EBM_WORD_W-1:0] rdData
);
    // ----------
    // Helpers
    // ----------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic rdClkQ_r;
    logic rdQual;
    logic badAddr;
    // Either pin edge counts, polarity lives in CTRL we cannot see
    always_ff @(posedge clock) begin
        rdClkQ_r <= rdClk;
    end
    assign rdQual = (rdClk != rdClkQ_r) && rdEn && rdClkEn;
    assign badAddr = (paddr > `EBM_OFS_STATUS) || (paddr[1:0] != 2'h0);
    a_ready_timing: assert property (psel && !penable |-> ##2
        (pready && psel && penable)) else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_decode: assert property (pready |-> pslverr == badAddr)
        else $error("bad error flag");
    a_err_alone: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_wo_zero: assert property (pready && !pwrite &&
        paddr == `EBM_OFS_PLDATA |-> prdata == 32'h0)
        else $error("write-only reads nonzero");
    a_reset_out: assert property ($rose(rst_b) |->
        rdData == 16'h0 && prdata == 32'h0 && !pready)
        else $error("reset value");
    a_read_hold: assert property ($changed(rdData) |->
        $past(rdQual, 1) || $past(rdQual, 2) || $past(rdQual, 3))
        else $error("read data moved unqualified");
    c_err: cover property (pslverr);
    c_read: cover property ($changed(rdData));
    c_pre: cover property (pready && pwrite && paddr == `EBM_OFS_PLDATA);
endmodule

bind ebm_top ebm_top_props chk (.clock, .rst_b, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .rdClk, .rdClkEn, .rdEn, .rdData);

// ===== dv/ebm_top_test.sv
`timescale 1ns/1ps
`include "ebm_defs.svh"
// Self-checking bench: table of port accesses, then corner cases
module ebm_top_test
    import ebm_pkg::*;
();
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic wrClk, wrClkEn, wrEn, rdClk, rdClkEn, rdEn;
    logic [10:0] wrAddr, rdAddr;
    logic [15:0] wrData, wrMask, rdData, rd;
    int fails = 0;
    int check_count = 0;
    typedef struct packed {
        logic [1:0] org;
        logic we;
        logic [10:0] wa;
        logic [15:0] wd;
        logic [15:0] mk;
        logic [10:0] ra;
        logic [15:0] ex;
    } ebm_row_t;
    // Lane walk on word 5, then the top address in 2048x2
    ebm_row_t rows [8] = '{
        '{2'h0, 1'h1, 11'h005, 16'hA5C3, 16'h0000, 11'h005, 16'hA5C3},
        '{2'h0, 1'h1, 11'h005, 16'hFFFF, 16'hFF00, 11'h005, 16'hA5FF},
        '{2'h1, 1'h1, 11'h00B, 16'h003C, 16'hFFFF, 11'h00B, 16'h003C},
        '{2'h1, 1'h0, 11'h00A, 16'h0000, 16'h0000, 11'h00A, 16'h00FF},
        '{2'h2, 1'h1, 11'h017, 16'h0009, 16'h0000, 11'h017, 16'h0009},
        '{2'h3, 1'h1, 11'h02D, 16'h0001, 16'h0000, 11'h02D, 16'h0001},
        '{2'h0, 1'h0, 11'h000, 16'h0000, 16'h0000, 11'h005, 16'h94FF},
        '{2'h3, 1'h1, 11'h7FF, 16'h0002, 16'h0000, 11'h7FF, 16'h0002}};
    ebm_top uut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wrClk, .wrClkEn, .wrEn, .wrAddr,
        .wrData, .wrMask, .rdClk, .rdClkEn, .rdEn, .rdAddr, .rdData);
    ebm_fabric_model fab (.clock, .wrClk, .wrClkEn, .wrEn, .wrAddr,
        .wrData, .wrMask, .rdClk, .rdClkEn, .rdEn, .rdAddr, .rdData);
    // -----------
    // Helpers
    // -----------
    task automatic check(input string n, input logic [31:0] s,
            input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Holds the request until pready is seen, bounded wait
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("watchdog expired");
        wrap_up;
    end
    // -----------
    // Sequence
    // -----------
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, `EBM_OFS_CTRL, {30'h0, rows[i].org});
            fab.wr(rows[i].wa, rows[i].wd, rows[i].mk, rows[i].we, 1'b1);
            fab.rd(rows[i].ra, 1'b1, 1'b1, rd);
            check("table read", rd, rows[i].ex);
        end
        $display("table done");
        // Mid-run reset clears outputs and control, not contents;
        // the pointer is moved first so its reset value shows
        apb(1'b1, `EBM_OFS_PLADDR, 32'h33);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        check("rdData after reset", rdData, 16'h0);
        apb(1'b0, `EBM_OFS_CTRL, 32'h0);
        check("CTRL reset", q, 32'h0);
        apb(1'b0, `EBM_OFS_PLADDR, 32'h0);
        check("PLADDR reset", q, 32'h0);
        $display("reset done");
        fab.wr(11'h003, 16'h1111, 16'h0, 1'b1, 1'b1);
        fab.wr(11'h003, 16'h2222, 16'h0, 1'b1, 1'b0);
        fab.rd(11'h003, 1'b1, 1'b1, rd);
        check("clock enable low", rd, 16'h1111);
        fab.rd(11'h005, 1'b0, 1'b1, rd);
        check("read enable low", rd, 16'h1111);
        fab.rd(11'h005, 1'b1, 1'b0, rd);
        check("read clock enable low", rd, 16'h1111);
        $display("qualifiers done");
        apb(1'b1, `EBM_OFS_CTRL, 32'h0C);
        apb(1'b0, `EBM_OFS_CTRL, 32'h0);
        check("CTRL readback", q, 32'h0C);
        fab.wr(11'h006, 16'hBEEF, 16'h0, 1'b1, 1'b1);
        // A read taken on the rising pin edge would already show here
        fork
            fab.rd(11'h006, 1'b1, 1'b1, rd);
            begin
                repeat (4) @(posedge clock);
                check("no read on rise", rdData, 16'h1111);
            end
        join
        check("falling edges", rd, 16'hBEEF);
        apb(1'b1, `EBM_OFS_CTRL, 32'h0);
        $display("edges done");
        // Preload from word 0: first word must be skipped
        fab.wr(11'h000, 16'h1234, 16'h0, 1'b1, 1'b1);
        apb(1'b1, `EBM_OFS_CTRL, 32'h10);
        apb(1'b1, `EBM_OFS_PLADDR, 32'h0);
        apb(1'b1, `EBM_OFS_PLDATA, 32'hAAAA);
        apb(1'b1, `EBM_OFS_PLDATA, 32'h5555);
        // User writes stay shut out while preloading
        fab.wr(11'h001, 16'h0F0F, 16'h0, 1'b1, 1'b1);
        apb(1'b0, `EBM_OFS_PLADDR, 32'h0);
        check("pointer advance", q, 32'h2);
        apb(1'b0, `EBM_OFS_PLDATA, 32'h0);
        check("PLDATA reads", q, 32'h0);
        apb(1'b1, `EBM_OFS_CTRL, 32'h20);
        fab.wr(11'h001, 16'h0000, 16'h0, 1'b1, 1'b1);
        fab.rd(11'h000, 1'b1, 1'b1, rd);
        check("word zero kept", rd, 16'h1234);
        fab.rd(11'h001, 1'b1, 1'b1, rd);
        check("preload and lock", rd, 16'h5555);
        // Three committed writes and four reads since the reset
        apb(1'b0, `EBM_OFS_STATUS, 32'h0);
        check("STATUS counts", q, 32'h00040003);
        $display("preload done");
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped error", {q[30:0], e}, 32'h1);
        apb(1'b1, 12'h006, 32'h0);
        check("misaligned error", e, 1'b1);
        $display("refusals done");
        wrap_up;
    end
endmodule

// ===== logic/ebm_apb_regs.sv
`timescale 1ns/1ps
`include "ebm_defs.svh"
// APB slave holding control, preload pointer and status view
module ebm_apb_regs
    import ebm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] status,
    output ebm_ctrl_t ctrl,
    output logic preloadStb,
    output logic [7:0] preloadWord,
    output logic [15:0] preloadData
);

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [`EBM_CTRL_W-1:0] ctrl_r;
    logic [7:0] plAddr_r;

    //------------------------------------------------------------
    // Decode
    //------------------------------------------------------------
    wire hitCtrl = (paddr == `EBM_OFS_CTRL);
    wire hitPlAddr = (paddr == `EBM_OFS_PLADDR);
    wire hitPlData = (paddr == `EBM_OFS_PLDATA);
    wire hitStatus = (paddr == `EBM_OFS_STATUS);
    wire hitAny = hitCtrl | hitPlAddr | hitPlData | hitStatus;
    // Ready is raised one access cycle late, so every transfer
    // completes in its second access cycle
    wire access = psel & penable & ~pready_r;
    wire commit = psel & penable & pready_r;
    wire wrCommit = commit & pwrite & hitAny;
    wire [31:0] rdMux = hitCtrl ? {26'h0, ctrl_r} :
                        hitPlAddr ? {24'h000000, plAddr_r} :
                        hitStatus ? status : 32'h00000000;

    // Preload data passes straight to the array on the commit edge
    assign preloadStb = wrCommit & hitPlData;
    assign preloadWord = plAddr_r;
    assign preloadData = pwdata[15:0];
    assign ctrl = ebm_ctrl_t'(ctrl_r);
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Bus answer, registered
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= access;
            pslverr_r <= access & ~hitAny;
            prdata_r <= (access & ~pwrite) ? rdMux : 32'h00000000;
        end
    end

    // Writable registers; pointer steps after each preload word
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_r <= `EBM_CTRL_RST;
            plAddr_r <= `EBM_PLADDR_RST;
        end else if (wrCommit & hitCtrl) begin
            ctrl_r <= pwdata[`EBM_CTRL_W-1:0];
        end else if (wrCommit & hitPlAddr) begin
            plAddr_r <= pwdata[7:0];
        end else if (preloadStb) begin
            plAddr_r <= plAddr_r + 8'h01;
        end
    end

endmodule

// ===== logic/ebm_defs.svh
// Overview of operation
// - 4096 bits as 256x16, 512x8, 1024x4, 2048x2
// - Serves single, dual, pseudo-dual port or FIFO
// - Wide mode: mask bit 1 keeps stored bit
// - Port inputs registered before the array
// - Write needs write enable and write clock enable
// - Read needs read enable and read clock enable
// - Wide mode addresses are 8 bits each
// - Each port clock edge selectable, rising default
// - Contents preloadable before user operation
// - Preload plus disabled writes gives a ROM
// - Preload never writes location zero
`ifndef EBM_DEFS_SVH
`define EBM_DEFS_SVH

//------------------------------------------------------------
// Register byte offsets on the APB
//------------------------------------------------------------
`define EBM_OFS_CTRL 12'h000
`define EBM_OFS_PLADDR 12'h004
`define EBM_OFS_PLDATA 12'h008
`define EBM_OFS_STATUS 12'h00C

//------------------------------------------------------------
// Field widths and reset values
//------------------------------------------------------------
`define EBM_CTRL_W 6
`define EBM_CTRL_RST 6'h00
`define EBM_PLADDR_RST 8'h00
`define EBM_RDATA_RST 16'h0000

//------------------------------------------------------------
// Array geometry
//------------------------------------------------------------
`define EBM_WORDS 256
`define EBM_WORD_W 16
`define EBM_WIDX_W 8
`define EBM_UADDR_W 11

`endif

// ===== logic/ebm_pkg.sv
package ebm_pkg;

    // Organisation, order gives the lane-shift count 0..3
    typedef enum logic [1:0] {
        EBM_ORG_W16,
        EBM_ORG_W8,
        EBM_ORG_W4,
        EBM_ORG_W2
    } ebm_org_t;

    // Control register image, top bit first (org sits in bits 1:0)
    typedef struct packed {
        logic wrLock;
        logic preloadOn;
        logic rdFall;
        logic wrFall;
        ebm_org_t org;
    } ebm_ctrl_t;

    // Where a user address lands in the 256x16 array
    typedef struct packed {
        logic [7:0] word;
        logic [3:0] sh;
        logic [15:0] ones;
    } ebm_lane_t;

    // Captured write request
    typedef struct packed {
        logic [7:0] word;
        logic [15:0] data;
        logic [15:0] bitEn;
    } ebm_wreq_t;

endpackage

// ===== logic/ebm_port_edge.sv
`timescale 1ns/1ps
// Turns a sampled port clock pin into a one-cycle edge pulse
module ebm_port_edge
    import ebm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic pinClk,
    input wire logic fallSel,
    output logic edgePulse
);

    logic prev_r;

    // Previous pin level; reset low so a high pin at release
    // counts as one rising edge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= pinClk;
        end
    end

    // Polarity choice per port
    assign edgePulse = fallSel ? (prev_r & ~pinClk)
                               : (~prev_r & pinClk);

endmodule

// ===== logic/ebm_top.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ebm_defs.svh"
// 4-kbit block memory with separate write and read ports
module ebm_top
    import ebm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wrClk,
    input wire logic wrClkEn,
    input wire logic wrEn,
    input wire logic [`EBM_UADDR_W-1:0] wrAddr,
    input wire logic [`EBM_WORD_W-1:0] wrData,
    input wire logic [`EBM_WORD_W-1:0] wrMask,
    input wire logic rdClk,
    input wire logic rdClkEn,
    input wire logic rdEn,
    input wire logic [`EBM_UADDR_W-1:0] rdAddr,
    output logic [`EBM_WORD_W-1:0] rdData
);

    //------------------------------------------------------------
    // Address mapping helpers
    //------------------------------------------------------------

    // Narrow organisations are lanes of the 16-bit word: the low
    // user address bits pick the lane, the rest pick the word
    function automatic ebm_lane_t laneOf(
        input ebm_org_t org,
        input logic [10:0] a
    );
        ebm_lane_t l;
        l.word = a[7:0];
        l.sh = 4'h0;
        l.ones = 16'hFFFF;
        case (org)
            EBM_ORG_W16: begin
                l.word = a[7:0];
                l.sh = 4'h0;
                l.ones = 16'hFFFF;
            end
            EBM_ORG_W8: begin
                l.word = a[8:1];
                l.sh = {a[0], 3'b000};
                l.ones = 16'h00FF;
            end
            EBM_ORG_W4: begin
                l.word = a[9:2];
                l.sh = {a[1:0], 2'b00};
                l.ones = 16'h000F;
            end
            EBM_ORG_W2: begin
                l.word = a[10:3];
                l.sh = {a[2:0], 1'b0};
                l.ones = 16'h0003;
            end
            default: begin
                l.word = a[7:0];
                l.sh = 4'h0;
                l.ones = 16'hFFFF;
            end
        endcase
        return l;
    endfunction

    // Copies narrow write data into every lane; the bit enables
    // then decide which lane really changes
    function automatic logic [15:0] replicate(
        input ebm_org_t org,
        input logic [15:0] d
    );
        logic [15:0] r;
        r = d;
        case (org)
            EBM_ORG_W16: r = d;
            EBM_ORG_W8: r = {2{d[7:0]}};
            EBM_ORG_W4: r = {4{d[3:0]}};
            EBM_ORG_W2: r = {8{d[1:0]}};
            default: r = d;
        endcase
        return r;
    endfunction

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    ebm_ctrl_t ctrl;
    logic preloadStb;
    logic [7:0] preloadWord;
    logic [15:0] preloadData;
    logic wrEdge;
    logic rdEdge;
    ebm_wreq_t wrReq_r;
    logic wrPend_r;
    ebm_lane_t rdReq_r;
    logic rdPend_r;
    logic [`EBM_WORD_W-1:0] rdData_r;
    logic [15:0] wrCount_r;
    logic [15:0] rdCount_r;
    // 4096 bits, no reset: contents survive a logic reset
    logic [`EBM_WORD_W-1:0] mem [0:`EBM_WORDS-1];

    //------------------------------------------------------------
    // Bus slave and port clock edges
    //------------------------------------------------------------
    ebm_apb_regs uRegs (
        .clock(clock),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status({rdCount_r, wrCount_r}),
        .ctrl(ctrl),
        .preloadStb(preloadStb),
        .preloadWord(preloadWord),
        .preloadData(preloadData)
    );

    ebm_port_edge uWrEdge (
        .clock(clock),
        .rst_b(rst_b),
        .pinClk(wrClk),
        .fallSel(ctrl.wrFall),
        .edgePulse(wrEdge)
    );

    ebm_port_edge uRdEdge (
        .clock(clock),
        .rst_b(rst_b),
        .pinClk(rdClk),
        .fallSel(ctrl.rdFall),
        .edgePulse(rdEdge)
    );

    //------------------------------------------------------------
    // Port qualification
    //------------------------------------------------------------

    // User ports stay idle while preloading; the lock bit lets a
    // preloaded block behave as a ROM even if user logic errs
    wire userOn = ~ctrl.preloadOn;
    wire wrTake = wrEdge & wrEn & wrClkEn & userOn
                  & ~ctrl.wrLock;
    // Separate write and read takes let fabric logic build single,
    // dual, pseudo-dual port or FIFO use around one array
    wire rdTake = rdEdge & rdEn & rdClkEn & userOn;

    wire ebm_lane_t wrLane = laneOf(ctrl.org, wrAddr);
    wire ebm_lane_t rdLane = laneOf(ctrl.org, rdAddr);
    // Mask is active only in the 16-bit organisation
    wire [15:0] wrBitEn = (ctrl.org == EBM_ORG_W16) ? ~wrMask
                          : (wrLane.ones << wrLane.sh);
    wire [15:0] wrRepl = replicate(ctrl.org, wrData);

    // Location zero is never preloaded
    wire preloadOk = preloadStb & ctrl.preloadOn
                     & (preloadWord != 8'h00);

    //------------------------------------------------------------
    // Input registers in front of the array
    //------------------------------------------------------------

    // Capture address, data and enables on the qualified edge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrReq_r <= '0;
        end else begin
            wrPend_r <= wrTake;
            if (wrTake) begin
                wrReq_r <= '{word: wrLane.word, data: wrRepl,
                             bitEn: wrBitEn};
            end
        end
    end

    // Read address captured the same way
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdPend_r <= 1'b0;
            rdReq_r <= '0;
        end else begin
            rdPend_r <= rdTake;
            if (rdTake) begin
                rdReq_r <= rdLane;
            end
        end
    end

    //------------------------------------------------------------
    // Storage array
    //------------------------------------------------------------

    // One write path per bit lane chosen by bitEn; preload and a
    // user write never overlap since preload idles the user port
    always_ff @(posedge clock) begin
        if (wrPend_r) begin
            mem[wrReq_r.word] <= (mem[wrReq_r.word] & ~wrReq_r.bitEn)
                                 | (wrReq_r.data & wrReq_r.bitEn);
        end
        if (preloadOk) begin
            mem[preloadWord] <= preloadData;
        end
    end

    // Read before write: a same-cycle commit shows next read
    wire [15:0] rdWord = mem[rdReq_r.word];
    wire [15:0] rdField = (rdWord >> rdReq_r.sh) & rdReq_r.ones;

    // Output holds between qualified reads
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdData_r <= `EBM_RDATA_RST;
        end else if (rdPend_r) begin
            rdData_r <= rdField;
        end
    end

    assign rdData = rdData_r;

    //------------------------------------------------------------
    // Activity counters for status, wrap at 16 bits
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrCount_r <= 16'h0000;
            rdCount_r <= 16'h0000;
        end else begin
            wrCount_r <= wrCount_r + {15'h0, wrPend_r};
            rdCount_r <= rdCount_r + {15'h0, rdPend_r};
        end
    end

endmodule
